// ===== pcr_defs.vh
// Constants for the persistent configuration register block
// Summary of operation
// - Read and write via dedicated serial commands
// - Reset copies persistent value into working configuration
// - Reserved write ignored, protection flag set, latch cleared
// - Bits 15:12 dummy count, 0 and F default
// - Bits 11:9 power-on execute-in-place mode select
// - Bits 8:6 drive setting, even codes reserved
// - Bit 5 low enables double-edge transfer
// - Bit 4 high enables pause/restart on line three
// - Bits 3/2 quad/dual low active, both gives quad
// - Bit 1 picks default 128Mb segment
// - Bit 0 low selects four-byte addressing
// - Extended address segment reset per bit 1
// - Controller status busy during persistent write
// - Protection flag held until clear-flags command or reset
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH
`define PCR_CMD_READ 8'hB5
`define PCR_CMD_WRITE 8'hB1
`define PCR_CMD_WREN 8'h06
`define PCR_CMD_CLRFLAG 8'h50
`define PCR_RESET_VALUE 16'hFFFF
`define PCR_DUMMY_DEFAULT 4'hA
`define PCR_WRITE_TIME_US 2
`define PCR_CLK_MHZ 100
// Two microseconds of busy time at 100 MHz, sized for the busy counter
`define PCR_WRITE_CYCLES 9'h0C8
`define PCR_SEG_HIGH 4'hF
`define PCR_SEG_LOW 4'h0
`endif

// ===== pcr_sync.v
// Two-flop synchroniser for link pins
`timescale 1ns/1ps
module pcr_sync (
    input wire clk,
    input wire rst,
    input wire d,
    output reg q
);
    reg meta_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // pcr_sync

// ===== pcr_top.v
// Persistent configuration register with serial command front end
`timescale 1ns/1ps
`include "pcr_defs.vh"
module pcr_top (
    input wire clk,
    input wire rst,
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso,
    output reg miso_oe_n,
    output reg [3:0] dummy_cycles,
    output reg [2:0] execute_in_place_mode,
    output reg [2:0] drive_setting,
    output reg double_edge_en,
    output reg data_line_three_pause_en,
    output reg quad_en,
    output reg dual_en,
    output reg four_byte_addr,
    output reg [3:0] ext_addr_segment,
    output reg [7:0] flag_status,
    output reg write_enable_latch
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    wire sclk_s;
    wire cs_act_s;
    wire mosi_s;
    pcr_sync u_sclk (.clk(clk), .rst(rst), .d(sclk), .q(sclk_s));
    // Synchronised active high so its reset state matches an idle pin
    pcr_sync u_cs (.clk(clk), .rst(rst), .d(~cs_n), .q(cs_act_s));
    wire cs_n_s = ~cs_act_s;
    pcr_sync u_mosi (.clk(clk), .rst(rst), .d(mosi), .q(mosi_s));

    reg sclk_d_reg;
    reg cs_d_reg;
    wire rise = sclk_s & ~sclk_d_reg;
    wire fall = ~sclk_s & sclk_d_reg;
    wire cs_end = cs_n_s & ~cs_d_reg;

    localparam [3:0] ST_CMD = 4'h1;
    localparam [3:0] ST_RD = 4'h2;
    localparam [3:0] ST_WR = 4'h4;
    localparam [3:0] ST_IGN = 4'h8;

    reg [3:0] state_reg;
    reg [4:0] bit_cnt_reg;
    reg [15:0] shift_reg;
    reg [15:0] tx_reg;
    // Blank nonvolatile state; rst must not touch these cells
    reg [15:0] persist_reg = `PCR_RESET_VALUE;
    reg [15:0] pending_reg;
    reg pending_valid_reg;
    reg [8:0] busy_cnt_reg;
    reg boot_reg;

    // Reserved encodings of a write value
    function reserved_code;
        input [15:0] v;
        begin
            reserved_code = (v[11:9] == 3'h5) || (v[11:9] == 3'h6) || (v[6] == 1'b0);
        end
    endfunction

    // Dummy count decode; codes 0 and F mean the default count
    function [3:0] dummy_decode;
        input [3:0] c;
        begin
            if (c == 4'h0 || c == 4'hF)
                dummy_decode = `PCR_DUMMY_DEFAULT;
            else
                dummy_decode = c;
        end
    endfunction

    // ------------------------------------------------------------
    // Serial command engine
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            state_reg <= ST_CMD;
            bit_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            miso <= 1'b0;
            miso_oe_n <= 1'b1;
            pending_reg <= 16'h0000;
            pending_valid_reg <= 1'b0;
            write_enable_latch <= 1'b0;
            flag_status <= 8'h80;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_n_s;
            pending_valid_reg <= 1'b0;
            // Busy while persistent write cycle runs
            flag_status[7] <= ~((busy_cnt_reg != 9'h000) | pending_valid_reg);
            // Follow the download in the same cycle so flag and mode never disagree
            flag_status[0] <= boot_reg ? ~persist_reg[0] : four_byte_addr;
            if (cs_n_s) begin
                state_reg <= ST_CMD;
                bit_cnt_reg <= 5'h00;
                miso_oe_n <= 1'b1;
                if (cs_end && state_reg == ST_WR && bit_cnt_reg == 5'h10) begin
                    if (reserved_code(shift_reg)) begin
                        flag_status[1] <= 1'b1;
                        write_enable_latch <= 1'b0;
                    end else begin
                        pending_reg <= shift_reg;
                        pending_valid_reg <= 1'b1;
                        write_enable_latch <= 1'b0;
                    end
                end
            end else if (rise) begin
                shift_reg <= {shift_reg[14:0], mosi_s};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                case (state_reg)
                    ST_CMD: begin
                        if (bit_cnt_reg == 5'h07) begin
                            bit_cnt_reg <= 5'h00;
                            case ({shift_reg[6:0], mosi_s})
                                `PCR_CMD_READ: begin
                                    state_reg <= ST_RD;
                                    tx_reg <= persist_reg;
                                end
                                `PCR_CMD_WRITE: begin
                                    // Busy or no latch: drop the data
                                    if (write_enable_latch && flag_status[7])
                                        state_reg <= ST_WR;
                                    else
                                        state_reg <= ST_IGN;
                                end
                                `PCR_CMD_WREN: begin
                                    write_enable_latch <= 1'b1;
                                    state_reg <= ST_IGN;
                                end
                                `PCR_CMD_CLRFLAG: begin
                                    flag_status[5:4] <= 2'h0;
                                    flag_status[1] <= 1'b0;
                                    state_reg <= ST_IGN;
                                end
                                default: state_reg <= ST_IGN;
                            endcase
                        end
                    end
                    ST_WR: begin
                        // Extra bits beyond 16 void the write
                        if (bit_cnt_reg == 5'h10)
                            state_reg <= ST_IGN;
                    end
                    ST_RD: begin
                        // Count runs on; bit 3 picks the byte
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                    default: bit_cnt_reg <= 5'h00;
                endcase
            end else if (fall && state_reg == ST_RD) begin
                // Low byte first, register value repeats
                miso_oe_n <= 1'b0;
                miso <= tx_reg[{bit_cnt_reg[3], 3'h7 - bit_cnt_reg[2:0]}];
            end
        end
    end

    // ------------------------------------------------------------
    // Persistent store and working configuration
    // ------------------------------------------------------------
    // Kept across rst so the next download sees the last committed value
    always @(posedge clk) begin
        if (pending_valid_reg)
            persist_reg <= pending_reg;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 9'h000;
        end else begin
            if (pending_valid_reg) begin
                busy_cnt_reg <= `PCR_WRITE_CYCLES;
            end else if (busy_cnt_reg != 9'h000) begin
                busy_cnt_reg <= busy_cnt_reg - 9'h001;
            end
        end
    end

    // Download happens once after each reset release
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_reg <= 1'b1;
            dummy_cycles <= `PCR_DUMMY_DEFAULT;
            execute_in_place_mode <= 3'h7;
            drive_setting <= 3'h7;
            double_edge_en <= 1'b0;
            data_line_three_pause_en <= 1'b1;
            quad_en <= 1'b0;
            dual_en <= 1'b0;
            four_byte_addr <= 1'b0;
            ext_addr_segment <= `PCR_SEG_LOW;
        end else if (boot_reg) begin
            boot_reg <= 1'b0;
            dummy_cycles <= dummy_decode(persist_reg[15:12]);
            execute_in_place_mode <= persist_reg[11:9];
            drive_setting <= persist_reg[8:6];
            double_edge_en <= ~persist_reg[5];
            data_line_three_pause_en <= persist_reg[4];
            quad_en <= ~persist_reg[3];
            dual_en <= ~persist_reg[2] & persist_reg[3];
            four_byte_addr <= ~persist_reg[0];
            ext_addr_segment <= persist_reg[1] ? `PCR_SEG_LOW : `PCR_SEG_HIGH;
        end
    end
endmodule // pcr_top

// ===== pcr_properties.sv
// Port-level assertions for the persistent configuration register
`timescale 1ns/1ps
module pcr_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic [3:0] dummy_cycles,
    input wire logic [2:0] execute_in_place_mode,
    input wire logic [2:0] drive_setting,
    input wire logic double_edge_en,
    input wire logic data_line_three_pause_en,
    input wire logic quad_en,
    input wire logic dual_en,
    input wire logic four_byte_addr,
    input wire logic [3:0] ext_addr_segment,
    input wire logic [7:0] flag_status,
    input wire logic write_enable_latch
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    dummy_code_used_a: assert property (dummy_cycles != 4'h0 && dummy_cycles != 4'hF)
        else $error("dummy count shows an unused code");
    exec_mode_legal_a: assert property (!(execute_in_place_mode inside {3'h5, 3'h6}))
        else $error("execute-in-place mode shows a reserved code");
    drive_code_odd_a: assert property (drive_setting[0])
        else $error("drive setting shows an even code");
    protocol_exclusive_a: assert property (!(quad_en && dual_en))
        else $error("quad and dual both active");
    addr_flag_match_a: assert property (flag_status[0] == four_byte_addr)
        else $error("addressing flag differs from address width");
    // Working set may only move on the download edge after reset
    working_hold_a: assert property (!$past(rst, 2) |-> $stable({dummy_cycles,
        execute_in_place_mode, drive_setting, double_edge_en, data_line_three_pause_en,
        quad_en, dual_en, four_byte_addr, ext_addr_segment}))
        else $error("working configuration changed outside reset");
    busy_hold_a: assert property ($fell(flag_status[7]) |-> !flag_status[7] [*8])
        else $error("controller busy ended too soon");
    reserved_latch_a: assert property ($rose(flag_status[1]) |-> ##[0:2] !write_enable_latch)
        else $error("latch still set after reserved write");
endmodule // pcr_properties

bind pcr_top pcr_properties u_props (.*);

// ===== pcr_host_model.sv
// Host serial controller model driving the configuration link
`timescale 1ns/1ps
module pcr_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Mode 0: data set while clock low, sampled on the rise
    task automatic bit_xfer(input logic b, output logic r);
        mosi = b;
        #62.5 sclk = 1'b1;
        r = miso;
        #62.5 sclk = 1'b0;
    endtask
    // Read data comes low byte first, each byte MSB first
    task automatic frame(input logic [7:0] cmd, input int nbits, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic r;
        cs_n = 1'b0;
        #62.5;
        for (int i = 7; i >= 0; i--) bit_xfer(cmd[i], r);
        for (int i = 0; i < nbits; i++) begin
            bit_xfer(wd[15 - i], r);
            rd[(i < 8) ? 7 - i : 23 - i] = r;
        end
        cs_n = 1'b1;
        #500;
    endtask
endmodule // pcr_host_model

// ===== persistent_config_register_tb_top.sv
// Self-checking bench for the persistent configuration register
`timescale 1ns/1ps
`include "pcr_defs.vh"
module persistent_config_register_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire sclk, cs_n, mosi, miso, miso_oe_n, double_edge_en, data_line_three_pause_en;
    wire quad_en, dual_en, four_byte_addr, write_enable_latch;
    wire [3:0] dummy_cycles, ext_addr_segment;
    wire [2:0] execute_in_place_mode, drive_setting;
    wire [7:0] flag_status;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] rd;
    always #5 clk = ~clk;
    pcr_top DUT (.*);
    pcr_host_model host (.*);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] working();
        return {dummy_cycles, execute_in_place_mode, drive_setting, double_edge_en,
                data_line_three_pause_en, quad_en, dual_en, four_byte_addr};
    endfunction
    task automatic do_reset;
        @(posedge clk) #1 rst = 1'b1;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic test_defaults;
        chk("working", 16'h57E8, working());
        chk("segment flags latch", 16'h0100, {ext_addr_segment, flag_status, write_enable_latch});
        host.frame(`PCR_CMD_READ, 16, 16'h0000, rd);
        chk("persistent", `PCR_RESET_VALUE, rd);
        $display("test_defaults done");
    endtask
    task automatic test_write;
        host.frame(`PCR_CMD_WREN, 0, 16'h0000, rd);
        chk("latch", 16'h0001, write_enable_latch);
        // Five dummy cycles: ample for this slow link clock
        host.frame(`PCR_CMD_WRITE, 16, 16'h52C4, rd);
        chk("ready", 16'h0000, flag_status[7]);
        for (int i = 0; i < 400 && flag_status[7] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("ready", 16'h0001, flag_status[7]);
        chk("working", 16'h57E8, working());
        host.frame(`PCR_CMD_READ, 16, 16'h0000, rd);
        chk("persistent", 16'h52C4, rd);
        $display("test_write done");
    endtask
    task automatic test_reserved;
        host.frame(`PCR_CMD_WREN, 0, 16'h0000, rd);
        host.frame(`PCR_CMD_WRITE, 16, 16'hFBFF, rd);
        chk("protect latch", 16'h0002, {flag_status[1], write_enable_latch});
        host.frame(`PCR_CMD_READ, 16, 16'h0000, rd);
        chk("persistent", 16'h52C4, rd);
        chk("protect", 16'h0001, flag_status[1]);
        host.frame(`PCR_CMD_CLRFLAG, 0, 16'h0000, rd);
        chk("protect", 16'h0000, flag_status[1]);
        host.frame(`PCR_CMD_WREN, 0, 16'h0000, rd);
        host.frame(`PCR_CMD_WRITE, 16, 16'h5284, rd);
        chk("drive protect latch", 16'h0002, {flag_status[1], write_enable_latch});
        host.frame(`PCR_CMD_CLRFLAG, 0, 16'h0000, rd);
        chk("protect", 16'h0000, flag_status[1]);
        $display("test_reserved done");
    endtask
    task automatic test_reset_keeps;
        chk("working", 16'h2975, working());
        chk("segment flags latch", 16'h1F02, {ext_addr_segment, flag_status, write_enable_latch});
        host.frame(`PCR_CMD_READ, 16, 16'h0000, rd);
        chk("persistent", 16'h52C4, rd);
        chk("output enable", 16'h0001, miso_oe_n);
        $display("test_reset_keeps done");
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        test_defaults;
        test_write;
        test_reserved;
        do_reset;
        test_reset_keeps;
        complete_run;
    end
    // Tests need about 35 us; nearly six times that means a hang
    initial begin
        #200000;
        num_errors++;
        complete_run;
    end
endmodule // persistent_config_register_tb_top
